// ---- src/crf_regs.vh ----
`ifndef CRF_REGS_VH
`define CRF_REGS_VH

// ----------------------------------------
// Register selector codes
// ----------------------------------------
`define CRF_SEL_R0    5'h00
`define CRF_SEL_R1    5'h01
`define CRF_SEL_R2    5'h02
`define CRF_SEL_R3    5'h03
`define CRF_SEL_R0L   5'h04
`define CRF_SEL_R0H   5'h05
`define CRF_SEL_R1L   5'h06
`define CRF_SEL_R1H   5'h07
`define CRF_SEL_DPL   5'h08
`define CRF_SEL_DPH   5'h09
`define CRF_SEL_A0    5'h0A
`define CRF_SEL_A1    5'h0B
`define CRF_SEL_AP    5'h0C
`define CRF_SEL_FB    5'h0D
`define CRF_SEL_SB    5'h0E
`define CRF_SEL_VTB   5'h0F
`define CRF_SEL_USP   5'h10
`define CRF_SEL_ISP   5'h11
`define CRF_SEL_SP    5'h12
`define CRF_SEL_FLG   5'h13
`define CRF_SEL_PC    5'h14

// ----------------------------------------
// Banked slot numbers within one bank
// ----------------------------------------
`define CRF_SLOT_R0   3'h0
`define CRF_SLOT_R1   3'h1
`define CRF_SLOT_R2   3'h2
`define CRF_SLOT_R3   3'h3
`define CRF_SLOT_A0   3'h4
`define CRF_SLOT_A1   3'h5
`define CRF_SLOT_FB   3'h6
`define CRF_BANK_SZ   4'h7
`define CRF_NSLOT     14

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define CRF_FLG_C     0
`define CRF_FLG_D     1
`define CRF_FLG_Z     2
`define CRF_FLG_S     3
`define CRF_FLG_B     4
`define CRF_FLG_O     5
`define CRF_FLG_I     6
`define CRF_FLG_U     7

// ----------------------------------------
// Result sizes and reset values
// ----------------------------------------
`define CRF_SZ_BYTE   2'h0
`define CRF_SZ_WORD   2'h1
`define CRF_RST16     16'h0000
`define CRF_RST20     20'h00000
`define CRF_FLG_RST   11'h000

`endif

// ---- src/crf_top.v ----
`timescale 1ns/1ps
`include "crf_regs.vh"

// Function
// - Four 16-bit general data registers
// - First two data registers split into bytes
// - Pairs two-over-zero and three-over-one form 32 bits
// - Two 16-bit address registers, general use too
// - Address one over zero forms 32 bits
// - 16-bit frame base register
// - 20-bit vector table base register
// - 20-bit program counter holds next address
// - User and interrupt stack, flag selected
// - 16-bit static base register
// - 11-bit flag register of processor state
// - Carry flag takes carry, borrow, shift-out
// - Zero flag set on zero result
// - Sign flag set on negative result
// - Bank flag steers banked register accesses
// - Overflow flag set on signed overflow
module crf_top (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        wr_en,
  input  wire [4:0]  wr_sel,
  input  wire [31:0] wr_data,
  input  wire [4:0]  rd_a_sel,
  input  wire [4:0]  rd_b_sel,
  output reg  [31:0] rd_a_data,
  output reg  [31:0] rd_b_data,
  input  wire        alu_upd_c,
  input  wire        alu_upd_zs,
  input  wire        alu_upd_o,
  input  wire [1:0]  alu_size,
  input  wire [31:0] alu_result,
  input  wire        alu_carry,
  input  wire        alu_ovf,
  input  wire        pc_adv,
  input  wire [2:0]  pc_step,
  input  wire        sp_wr_en,
  input  wire [15:0] sp_wr_data,
  output wire [19:0] program_counter,
  output wire [15:0] stack_pointer,
  output wire [10:0] flag_register,
  output wire [15:0] frame_base,
  output wire [15:0] static_base,
  output wire [19:0] vector_table_base,
  output wire [15:0] addr_reg_zero,
  output wire [15:0] addr_reg_one
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Both banks in one array: bank 0 in slots 0..6, bank 1 in 7..13
  reg  [15:0] bank_q [0:`CRF_NSLOT-1];
  reg  [15:0] sb_q;
  reg  [19:0] vtb_q;
  reg  [19:0] pc_q;
  reg  [19:0] pc_d;
  reg  [15:0] usp_q;
  reg  [15:0] isp_q;
  reg  [10:0] flg_q;
  reg  [10:0] flg_d;
  reg         z_res;
  reg         s_res;
  wire        bsel;
  wire        usel;
  wire [15:0] cur_reg [0:6];
  integer     i;

  assign bsel = flg_q[`CRF_FLG_B];
  assign usel = flg_q[`CRF_FLG_U];

  // ----------------------------------------
  // Bank decode
  // ----------------------------------------
  function [3:0] crf_slot;
    input       bank;
    input [2:0] k;
    begin
      crf_slot = bank ? ({1'b0, k} + `CRF_BANK_SZ) : {1'b0, k};
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_cur
      localparam [2:0] K = g;
      assign cur_reg[g] = bank_q[crf_slot(bsel, K)];
    end
  endgenerate

  // ----------------------------------------
  // Read decode, shared by both read ports
  // ----------------------------------------
  // Byte and long views are built from the same words, so no alias can go stale
  function [31:0] crf_read;
    input [4:0] sel;
    begin
      case (sel)
        `CRF_SEL_R0:  crf_read = {16'h0000, cur_reg[`CRF_SLOT_R0]};
        `CRF_SEL_R1:  crf_read = {16'h0000, cur_reg[`CRF_SLOT_R1]};
        `CRF_SEL_R2:  crf_read = {16'h0000, cur_reg[`CRF_SLOT_R2]};
        `CRF_SEL_R3:  crf_read = {16'h0000, cur_reg[`CRF_SLOT_R3]};
        `CRF_SEL_R0L: crf_read = {24'h000000, cur_reg[`CRF_SLOT_R0][7:0]};
        `CRF_SEL_R0H: crf_read = {24'h000000, cur_reg[`CRF_SLOT_R0][15:8]};
        `CRF_SEL_R1L: crf_read = {24'h000000, cur_reg[`CRF_SLOT_R1][7:0]};
        `CRF_SEL_R1H: crf_read = {24'h000000, cur_reg[`CRF_SLOT_R1][15:8]};
        `CRF_SEL_DPL: crf_read = {cur_reg[`CRF_SLOT_R2], cur_reg[`CRF_SLOT_R0]};
        `CRF_SEL_DPH: crf_read = {cur_reg[`CRF_SLOT_R3], cur_reg[`CRF_SLOT_R1]};
        `CRF_SEL_A0:  crf_read = {16'h0000, cur_reg[`CRF_SLOT_A0]};
        `CRF_SEL_A1:  crf_read = {16'h0000, cur_reg[`CRF_SLOT_A1]};
        `CRF_SEL_AP:  crf_read = {cur_reg[`CRF_SLOT_A1], cur_reg[`CRF_SLOT_A0]};
        `CRF_SEL_FB:  crf_read = {16'h0000, cur_reg[`CRF_SLOT_FB]};
        `CRF_SEL_SB:  crf_read = {16'h0000, sb_q};
        `CRF_SEL_VTB: crf_read = {12'h000, vtb_q};
        `CRF_SEL_USP: crf_read = {16'h0000, usp_q};
        `CRF_SEL_ISP: crf_read = {16'h0000, isp_q};
        `CRF_SEL_SP:  crf_read = {16'h0000, usel ? isp_q : usp_q};
        `CRF_SEL_FLG: crf_read = {21'h000000, flg_q};
        `CRF_SEL_PC:  crf_read = {12'h000, pc_q};
        default:      crf_read = 32'h00000000;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Flag next value
  // ----------------------------------------
  always @* begin
    case (alu_size)
      `CRF_SZ_BYTE: begin
        z_res = (alu_result[7:0] == 8'h00);
        s_res = alu_result[7];
      end
      `CRF_SZ_WORD: begin
        z_res = (alu_result[15:0] == 16'h0000);
        s_res = alu_result[15];
      end
      default: begin
        z_res = (alu_result == 32'h00000000);
        s_res = alu_result[31];
      end
    endcase
    flg_d = flg_q;
    // An explicit flag write overrides arithmetic updates in the same cycle
    if (wr_en && (wr_sel == `CRF_SEL_FLG)) begin
      flg_d = wr_data[10:0];
    end else begin
      if (alu_upd_c) begin
        flg_d[`CRF_FLG_C] = alu_carry;
      end
      if (alu_upd_zs) begin
        flg_d[`CRF_FLG_Z] = z_res;
        flg_d[`CRF_FLG_S] = s_res;
      end
      if (alu_upd_o) begin
        flg_d[`CRF_FLG_O] = alu_ovf;
      end
    end
  end

  // ----------------------------------------
  // Program counter next value
  // ----------------------------------------
  always @* begin
    pc_d = pc_q;
    if (wr_en && (wr_sel == `CRF_SEL_PC)) begin
      pc_d = wr_data[19:0];
    end else if (pc_adv) begin
      pc_d = pc_q + {17'h00000, pc_step};
    end
  end

  // ----------------------------------------
  // Banked registers
  // ----------------------------------------
  // Writes use the bank in force before this edge; a flag write lands after
  always @(posedge clk) begin
    if (!rst_b) begin
      for (i = 0; i < `CRF_NSLOT; i = i + 1) begin
        bank_q[i] <= `CRF_RST16;
      end
    end else if (wr_en) begin
      case (wr_sel)
        `CRF_SEL_R0: bank_q[crf_slot(bsel, `CRF_SLOT_R0)] <= wr_data[15:0];
        `CRF_SEL_R1: bank_q[crf_slot(bsel, `CRF_SLOT_R1)] <= wr_data[15:0];
        `CRF_SEL_R2: bank_q[crf_slot(bsel, `CRF_SLOT_R2)] <= wr_data[15:0];
        `CRF_SEL_R3: bank_q[crf_slot(bsel, `CRF_SLOT_R3)] <= wr_data[15:0];
        `CRF_SEL_R0L: begin
          bank_q[crf_slot(bsel, `CRF_SLOT_R0)] <=
            {cur_reg[`CRF_SLOT_R0][15:8], wr_data[7:0]};
        end
        `CRF_SEL_R0H: begin
          bank_q[crf_slot(bsel, `CRF_SLOT_R0)] <=
            {wr_data[7:0], cur_reg[`CRF_SLOT_R0][7:0]};
        end
        `CRF_SEL_R1L: begin
          bank_q[crf_slot(bsel, `CRF_SLOT_R1)] <=
            {cur_reg[`CRF_SLOT_R1][15:8], wr_data[7:0]};
        end
        `CRF_SEL_R1H: begin
          bank_q[crf_slot(bsel, `CRF_SLOT_R1)] <=
            {wr_data[7:0], cur_reg[`CRF_SLOT_R1][7:0]};
        end
        `CRF_SEL_DPL: begin
          bank_q[crf_slot(bsel, `CRF_SLOT_R0)] <= wr_data[15:0];
          bank_q[crf_slot(bsel, `CRF_SLOT_R2)] <= wr_data[31:16];
        end
        `CRF_SEL_DPH: begin
          bank_q[crf_slot(bsel, `CRF_SLOT_R1)] <= wr_data[15:0];
          bank_q[crf_slot(bsel, `CRF_SLOT_R3)] <= wr_data[31:16];
        end
        `CRF_SEL_A0: bank_q[crf_slot(bsel, `CRF_SLOT_A0)] <= wr_data[15:0];
        `CRF_SEL_A1: bank_q[crf_slot(bsel, `CRF_SLOT_A1)] <= wr_data[15:0];
        `CRF_SEL_AP: begin
          bank_q[crf_slot(bsel, `CRF_SLOT_A0)] <= wr_data[15:0];
          bank_q[crf_slot(bsel, `CRF_SLOT_A1)] <= wr_data[31:16];
        end
        `CRF_SEL_FB: bank_q[crf_slot(bsel, `CRF_SLOT_FB)] <= wr_data[15:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Unbanked registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      sb_q  <= `CRF_RST16;
      vtb_q <= `CRF_RST20;
      pc_q  <= `CRF_RST20;
      usp_q <= `CRF_RST16;
      isp_q <= `CRF_RST16;
      flg_q <= `CRF_FLG_RST;
    end else begin
      pc_q  <= pc_d;
      flg_q <= flg_d;
      if (wr_en && (wr_sel == `CRF_SEL_SB)) begin
        sb_q <= wr_data[15:0];
      end
      if (wr_en && (wr_sel == `CRF_SEL_VTB)) begin
        vtb_q <= wr_data[19:0];
      end
      // Stack port wins over a general write to the same pointer
      if (sp_wr_en && !usel) begin
        usp_q <= sp_wr_data;
      end else if (wr_en && ((wr_sel == `CRF_SEL_USP) ||
                             ((wr_sel == `CRF_SEL_SP) && !usel))) begin
        usp_q <= wr_data[15:0];
      end
      if (sp_wr_en && usel) begin
        isp_q <= sp_wr_data;
      end else if (wr_en && ((wr_sel == `CRF_SEL_ISP) ||
                             ((wr_sel == `CRF_SEL_SP) && usel))) begin
        isp_q <= wr_data[15:0];
      end
    end
  end

  // ----------------------------------------
  // Read ports, one cycle after the select
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      rd_a_data <= 32'h00000000;
      rd_b_data <= 32'h00000000;
    end else begin
      rd_a_data <= crf_read(rd_a_sel);
      rd_b_data <= crf_read(rd_b_sel);
    end
  end

  // ----------------------------------------
  // Direct views for address generation
  // ----------------------------------------
  // Muxed between flops, so they follow a bank or stack switch at once
  assign program_counter   = pc_q;
  assign stack_pointer     = usel ? isp_q : usp_q;
  assign flag_register     = flg_q;
  assign frame_base        = cur_reg[`CRF_SLOT_FB];
  assign static_base       = sb_q;
  assign vector_table_base = vtb_q;
  assign addr_reg_zero     = cur_reg[`CRF_SLOT_A0];
  assign addr_reg_one      = cur_reg[`CRF_SLOT_A1];

endmodule

// ---- test/crf_checker.sv ----
`timescale 1ns/1ps
`include "crf_regs.vh"
// ----
// Port checker
// ----
module crf_checker (
  input logic        clk,
  input logic        rst_b,
  input logic        wr_en,
  input logic [4:0]  wr_sel,
  input logic [31:0] wr_data,
  input logic        alu_upd_c,
  input logic        alu_upd_zs,
  input logic        alu_upd_o,
  input logic [1:0]  alu_size,
  input logic [31:0] alu_result,
  input logic        alu_carry,
  input logic        alu_ovf,
  input logic        pc_adv,
  input logic [2:0]  pc_step,
  input logic        sp_wr_en,
  input logic [15:0] sp_wr_data,
  input logic [19:0] program_counter,
  input logic [15:0] stack_pointer,
  input logic [10:0] flag_register,
  input logic [15:0] frame_base,
  input logic [15:0] static_base,
  input logic [15:0] addr_reg_zero,
  input logic [15:0] addr_reg_one
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A flag write wins over the arithmetic updates
  wire flg_wr = wr_en && wr_sel == `CRF_SEL_FLG;
  sequence s_pair_wr; wr_en && wr_sel == `CRF_SEL_AP; endsequence
  sequence s_word_zs; alu_upd_zs && !flg_wr && alu_size == `CRF_SZ_WORD; endsequence
  property p_pair; s_pair_wr |=> {addr_reg_one, addr_reg_zero} == $past(wr_data); endproperty
  a_pair: assert property (p_pair) else $error("pair write mismatch");
  property p_fb; wr_en && wr_sel == `CRF_SEL_FB |=> frame_base == $past(wr_data[15:0]); endproperty
  a_fb: assert property (p_fb) else $error("frame base mismatch");
  property p_sb; wr_en && wr_sel == `CRF_SEL_SB |=> static_base == $past(wr_data[15:0]); endproperty
  a_sb: assert property (p_sb) else $error("static base mismatch");
  property p_hold;
    !wr_en |=> $stable(frame_base) && $stable(addr_reg_zero) && $stable(addr_reg_one);
  endproperty
  a_hold: assert property (p_hold) else $error("banked value moved");
  property p_pc;
    pc_adv && !(wr_en && wr_sel == `CRF_SEL_PC)
      |=> program_counter == $past(program_counter) + {17'h00000, $past(pc_step)};
  endproperty
  a_pc: assert property (p_pc) else $error("pc advance mismatch");
  property p_carry;
    alu_upd_c && !flg_wr |=> flag_register[`CRF_FLG_C] == $past(alu_carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag mismatch");
  property p_ovf;
    alu_upd_o && !flg_wr |=> flag_register[`CRF_FLG_O] == $past(alu_ovf);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag mismatch");
  property p_zero;
    s_word_zs |=> flag_register[`CRF_FLG_Z] == ($past(alu_result[15:0]) == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag mismatch");
  property p_sign;
    alu_upd_zs && !flg_wr && alu_size == `CRF_SZ_BYTE
      |=> flag_register[`CRF_FLG_S] == $past(alu_result[7]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag mismatch");
  property p_stack; sp_wr_en && !flg_wr |=> stack_pointer == $past(sp_wr_data); endproperty
  a_stack: assert property (p_stack) else $error("stack pointer mismatch");
endmodule
bind crf_top crf_checker u_chk (.clk, .rst_b, .wr_en, .wr_sel, .wr_data, .alu_upd_c, .alu_upd_zs,
  .alu_upd_o, .alu_size, .alu_result, .alu_carry, .alu_ovf, .pc_adv, .pc_step, .sp_wr_en,
  .sp_wr_data, .program_counter, .stack_pointer, .flag_register, .frame_base, .static_base,
  .addr_reg_zero, .addr_reg_one);

// ---- test/crf_alu_model.sv ----
`timescale 1ns/1ps
// ----
// Behavioural adder in place of the core arithmetic unit
// ----
module crf_alu_model (
  input  logic [1:0]  alu_size,
  input  logic [31:0] op_a,
  input  logic [31:0] op_b,
  output logic [31:0] alu_result,
  output logic        alu_carry,
  output logic        alu_ovf
);
  logic [32:0] sum;
  int          msb;
  assign sum        = {1'b0, op_a} + {1'b0, op_b};
  assign msb        = (alu_size == 2'h0) ? 7 : (alu_size == 2'h1) ? 15 : 31;
  assign alu_result = sum[31:0];
  assign alu_carry  = sum[msb + 1];
  assign alu_ovf    = (op_a[msb] == op_b[msb]) && (sum[msb] != op_a[msb]);
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`include "crf_regs.vh"
module testbench;
  logic        clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, upd = 1'b0, pc_adv = 1'b0, sp_wr_en = 1'b0;
  logic [4:0]  wr_sel = 5'h00, rd_sel = 5'h00;
  logic [31:0] wr_data = 32'h0, op_a = 32'h0, op_b = 32'h0;
  logic [1:0]  alu_size = 2'h0;
  logic [2:0]  pc_step = 3'h0;
  logic [15:0] sp_wr_data = 16'h0;
  wire  [31:0] rd_a_data, rd_b_data, alu_result;
  wire         alu_carry, alu_ovf;
  wire  [19:0] program_counter, vector_table_base;
  wire  [15:0] stack_pointer, frame_base, static_base, addr_reg_zero, addr_reg_one;
  wire  [10:0] flag_register;
  int          err_count = 0, cmp_count = 0;
  // Row: write sel, write data, read sel, expected read
  logic [73:0] rows [16] = '{
    {`CRF_SEL_R0, 32'h00001234, `CRF_SEL_R0, 32'h00001234},
    {`CRF_SEL_R0H, 32'h000000AB, `CRF_SEL_R0, 32'h0000AB34},
    {`CRF_SEL_R0L, 32'h000000CD, `CRF_SEL_R0H, 32'h000000AB},
    {`CRF_SEL_R1, 32'h00005678, `CRF_SEL_R1L, 32'h00000078},
    {`CRF_SEL_R1H, 32'h000000EE, `CRF_SEL_R1, 32'h0000EE78},
    {`CRF_SEL_DPL, 32'hAAAA5555, `CRF_SEL_R2, 32'h0000AAAA},
    {`CRF_SEL_DPH, 32'h12345678, `CRF_SEL_R3, 32'h00001234},
    {`CRF_SEL_R3, 32'h0000BEEF, `CRF_SEL_DPH, 32'hBEEF5678},
    {`CRF_SEL_AP, 32'h87654321, `CRF_SEL_A1, 32'h00008765},
    {`CRF_SEL_A0, 32'h00001111, `CRF_SEL_AP, 32'h87651111},
    {`CRF_SEL_FB, 32'h0000F00D, `CRF_SEL_FB, 32'h0000F00D},
    {`CRF_SEL_SB, 32'h0000C0DE, `CRF_SEL_SB, 32'h0000C0DE},
    {`CRF_SEL_VTB, 32'h000ABCDE, `CRF_SEL_VTB, 32'h000ABCDE},
    {`CRF_SEL_USP, 32'h00000100, `CRF_SEL_USP, 32'h00000100},
    {`CRF_SEL_ISP, 32'h00000200, `CRF_SEL_SP, 32'h00000100},
    {5'h1F, 32'h0000FFFF, 5'h1F, 32'h00000000}};

  crf_alu_model u_alu (.alu_size, .op_a, .op_b, .alu_result, .alu_carry, .alu_ovf);
  crf_top dut (.clk, .rst_b, .wr_en, .wr_sel, .wr_data, .rd_a_sel(rd_sel), .rd_b_sel(rd_sel),
    .rd_a_data, .rd_b_data, .alu_upd_c(upd), .alu_upd_zs(upd), .alu_upd_o(upd), .alu_size,
    .alu_result, .alu_carry, .alu_ovf, .pc_adv, .pc_step, .sp_wr_en, .sp_wr_data,
    .program_counter, .stack_pointer, .flag_register, .frame_base, .static_base,
    .vector_table_base, .addr_reg_zero, .addr_reg_one);

  always #4 clk = ~clk;

  // ----
  // Tasks
  // ----
  task chk_rd(input logic [31:0] e);
    cmp_count++;
    if (rd_a_data !== e || rd_b_data !== e) begin
      err_count++;
      $display("CHECK FAILED %0t read %h exp %h", $time, rd_a_data, e);
    end
  endtask
  task chk_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t value %h exp %h", $time, g, e);
    end
  endtask
  // Strobe is dropped at the taking edge, so the next call waits a fresh edge
  task wr(input logic [4:0] s, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [4:0] s, input logic [31:0] e);
    @(posedge clk);
    rd_sel <= s;
    @(posedge clk);
    #1 chk_rd(e);
  endtask
  task alu(input logic [1:0] s, input logic [31:0] a, input logic [31:0] b,
           input logic [31:0] e);
    @(posedge clk);
    upd <= 1'b1;
    alu_size <= s;
    op_a <= a;
    op_b <= b;
    @(posedge clk);
    upd <= 1'b0;
    #1 chk_val({21'h0, flag_register}, e);
  endtask
  task summarize;
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk_val({1'b0, program_counter, flag_register}, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i][73:69], rows[i][68:37]);
      rd(rows[i][36:32], rows[i][31:0]);
    end
    #1 chk_val({12'h000, vector_table_base}, 32'h000ABCDE);
    // Flag values never set the debug bit
    wr(`CRF_SEL_FLG, 32'h00000010);
    #1 chk_val(frame_base, 32'h0);
    wr(`CRF_SEL_FB, 32'h00002222);
    wr(`CRF_SEL_FLG, 32'h00000000);
    #1 chk_val(frame_base, 32'h0000F00D);
    wr(`CRF_SEL_FLG, 32'h00000080);
    #1 chk_val(stack_pointer, 32'h00000200);
    @(posedge clk);
    sp_wr_en <= 1'b1;
    sp_wr_data <= 16'h4321;
    @(posedge clk);
    sp_wr_en <= 1'b0;
    wr(`CRF_SEL_FLG, 32'h00000000);
    #1 chk_val(stack_pointer, 32'h00000100);
    rd(`CRF_SEL_ISP, 32'h00004321);
    wr(`CRF_SEL_PC, 32'h000FFFFE);
    @(posedge clk);
    pc_adv <= 1'b1;
    pc_step <= 3'h4;
    @(posedge clk);
    pc_adv <= 1'b0;
    #1 chk_val(program_counter, 32'h00000002);
    alu(2'h0, 32'h000000FF, 32'h00000001, 32'h00000005);
    alu(2'h1, 32'h00007FFF, 32'h00000001, 32'h00000028);
    alu(2'h2, 32'hFFFFFFFF, 32'h00000001, 32'h00000005);
    alu(2'h3, 32'h80000000, 32'h80000000, 32'h00000025);
    alu(2'h1, 32'h00001234, 32'h00000001, 32'h00000000);
    summarize;
  end

  initial begin
    #20000;
    err_count++;
    summarize;
  end
endmodule
